// >>> hw/ssc_top.sv
// strap capture, U1/U2 policy and serial pin routing with AXI4-Lite regs
`timescale 1ns/1ns
`include "ssc_defines.svh"
`default_nettype none
module ssc_top
    import ssc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [`SSC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SSC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic serial_mode_select_n,
    input wire logic serial_clock_pin_in,
    output logic serial_clock_pin_out,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    input wire logic port2_green_led_used_strap_in,
    output logic port2_green_led_used_strap_out,
    output logic port2_green_led_used_strap_oe,
    input wire logic port3_green_led_used_strap_in,
    output logic port3_green_led_used_strap_out,
    output logic port3_green_led_used_strap_oe,
    // hub core side
    input wire logic [1:0] green_led_on,
    output logic [1:0] port_used,
    output var ssc_lp_t low_power,
    output logic straps_valid,
    // eeprom master engine side
    input wire logic eeprom_scl_drive_low,
    input wire logic eeprom_sda_drive_low,
    // smbus slave engine side
    input wire logic smbus_sda_drive_low,
    // synchronised pin levels and clock edges for both engines
    output logic serial_clock_level,
    output logic serial_data_level,
    output logic serial_clock_rise,
    output logic serial_clock_fall,
    output logic eeprom_mode
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation

    logic [4:0] pins_sync;
    logic clk_prev;

    ssc_sync #(
        .WIDTH(5)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in({serial_mode_select_n, port3_green_led_used_strap_in,
                   port2_green_led_used_strap_in, serial_data_pin_in,
                   serial_clock_pin_in}),
        .sync_out(pins_sync)
    );

    logic clk_s;
    logic dat_s;
    logic p2_s;
    logic p3_s;
    logic mode_s;

    assign clk_s = pins_sync[0];
    assign dat_s = pins_sync[1];
    assign p2_s = pins_sync[2];
    assign p3_s = pins_sync[3];
    assign mode_s = pins_sync[4];

    // edges are found on the synchronised copy only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= clk_s;
        end
    end

    assign serial_clock_level = clk_s;
    assign serial_data_level = dat_s;
    assign serial_clock_rise = clk_s && !clk_prev;
    assign serial_clock_fall = !clk_s && clk_prev;
    assign eeprom_mode = mode_s;

    ////////////////////////////////////////////////////////////////////////
    // strap capture

    ssc_state_t state;
    logic [`SSC_SETTLE_W-1:0] settle_cnt;
    ssc_straps_t straps;
    logic captured;

    assign captured = (state == SSC_RUN);
    assign straps_valid = captured;

    // the pins are sampled a fixed time after release so the
    // synchroniser holds the level the board strapped at release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= SSC_SETTLE;
            settle_cnt <= '0;
        end else begin
            case (state)
                SSC_SETTLE: begin
                    if (settle_cnt == `SSC_SETTLE_LAST) begin
                        state <= SSC_RUN;
                    end else begin
                        settle_cnt <= settle_cnt + 1'b1;
                    end
                end
                SSC_RUN: begin
                    state <= SSC_RUN;
                end
                default: begin
                    state <= SSC_SETTLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            straps <= '0;
        end else if (state == SSC_SETTLE &&
                     settle_cnt == `SSC_SETTLE_LAST) begin
            straps.port2_used <= p2_s;
            straps.port3_used <= p3_s;
            straps.serial_clock_strap <= clk_s;
            straps.serial_data_strap <= dat_s;
        end
    end

    assign port_used = {straps.port3_used, straps.port2_used};

    ////////////////////////////////////////////////////////////////////////
    // register file

    logic [1:0] devcfg;
    logic aw_held;
    logic w_held;
    logic [`SSC_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic [31:0] status_word;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr == `SSC_ADDR_DEVCFG ||
                            aw_addr == `SSC_ADDR_STATUS) ?
                           `SSC_RESP_OKAY : `SSC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // status is read-only; a write to it is accepted and dropped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            devcfg <= `SSC_DEVCFG_RESET;
        end else if (do_write && aw_addr == `SSC_ADDR_DEVCFG &&
                     w_strb[0]) begin
            devcfg <= w_data[1:0];
        end
    end

    always_comb begin
        status_word = '0;
        status_word[`SSC_ST_PORT2] = straps.port2_used;
        status_word[`SSC_ST_PORT3] = straps.port3_used;
        status_word[`SSC_ST_CLK] = straps.serial_clock_strap;
        status_word[`SSC_ST_DAT] = straps.serial_data_strap;
        status_word[`SSC_ST_MODE] = mode_s;
        status_word[`SSC_ST_DONE] = captured;
        status_word[`SSC_ST_LP_EN] = low_power.enable;
        status_word[`SSC_ST_INIT_EN] = low_power.initiate_enable;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `SSC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            case (s_axi_araddr)
                `SSC_ADDR_STATUS: begin
                    s_axi_rdata <= status_word;
                    s_axi_rresp <= `SSC_RESP_OKAY;
                end
                `SSC_ADDR_DEVCFG: begin
                    s_axi_rdata <= {30'h0, devcfg};
                    s_axi_rresp <= `SSC_RESP_OKAY;
                end
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `SSC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // U1/U2 policy

    ssc_lp_t next_low_power;
    logic cfg_present;
    logic cfg_lp_dis;

    assign cfg_present = devcfg[`SSC_DEVCFG_PRESENT];
    assign cfg_lp_dis = devcfg[`SSC_DEVCFG_LP_DIS];

    // acceptance of partner-requested entry follows enable alone
    always_comb begin
        if (!captured) begin
            next_low_power = '0;
        end else if (cfg_present) begin
            next_low_power.enable = !cfg_lp_dis;
            next_low_power.initiate_enable = !cfg_lp_dis;
        end else if (straps.serial_data_strap) begin
            next_low_power = '0;
        end else begin
            next_low_power.enable = 1'b1;
            next_low_power.initiate_enable =
                !straps.serial_clock_strap;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_power <= '0;
        end else begin
            low_power <= next_low_power;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    // open-drain: out stays low, oe pulls the wire; nothing is driven
    // until capture so the board straps are never overridden
    assign serial_clock_pin_out = 1'b0;
    assign serial_data_pin_out = 1'b0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_clock_pin_oe <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else if (!captured) begin
            serial_clock_pin_oe <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else if (mode_s) begin
            serial_clock_pin_oe <= eeprom_scl_drive_low;
            serial_data_pin_oe <= eeprom_sda_drive_low;
        end else begin
            serial_clock_pin_oe <= 1'b0;
            serial_data_pin_oe <= smbus_sda_drive_low;
        end
    end

    // led pins are active low, driven once the used straps are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port2_green_led_used_strap_oe <= 1'b0;
            port3_green_led_used_strap_oe <= 1'b0;
            port2_green_led_used_strap_out <= 1'b1;
            port3_green_led_used_strap_out <= 1'b1;
        end else begin
            port2_green_led_used_strap_oe <= captured;
            port3_green_led_used_strap_oe <= captured;
            port2_green_led_used_strap_out <= !green_led_on[0];
            port3_green_led_used_strap_out <= !green_led_on[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_release;
        $rose(aresetn);
    endsequence

    sequence s_settling;
        !captured [*3];
    endsequence

    property p_capture_time;
        @(posedge aclk) disable iff (!aresetn)
        s_release |-> s_settling ##1 captured;
    endproperty
    a_capture_time: assert property (p_capture_time)
        else $error("straps not captured three cycles after reset");

    property p_straps_held;
        @(posedge aclk) disable iff (!aresetn)
        captured && $past(captured) |-> $stable(straps);
    endproperty
    a_straps_held: assert property (p_straps_held)
        else $error("captured straps changed after capture");

    property p_used_taken;
        @(posedge aclk) disable iff (!aresetn)
        $rose(captured) |->
            port_used == $past({p3_s, p2_s}) &&
            straps.serial_data_strap == $past(dat_s);
    endproperty
    a_used_taken: assert property (p_used_taken)
        else $error("port used strap does not match pin at capture");

    property p_led_drive;
        @(posedge aclk) disable iff (!aresetn)
        captured |=> port2_green_led_used_strap_oe &&
            port3_green_led_used_strap_oe &&
            port2_green_led_used_strap_out == !$past(green_led_on[0]);
    endproperty
    a_led_drive: assert property (p_led_drive)
        else $error("green led not driven after capture");

    property p_no_drive_early;
        @(posedge aclk) disable iff (!aresetn)
        !captured |=> !port2_green_led_used_strap_oe &&
            !serial_clock_pin_oe && !serial_data_pin_oe;
    endproperty
    a_no_drive_early: assert property (p_no_drive_early)
        else $error("shared pin driven before strap capture");

    property p_eeprom_route;
        @(posedge aclk) disable iff (!aresetn)
        captured && mode_s |=>
            serial_clock_pin_oe == $past(eeprom_scl_drive_low) &&
            serial_data_pin_oe == $past(eeprom_sda_drive_low);
    endproperty
    a_eeprom_route: assert property (p_eeprom_route)
        else $error("eeprom mode pins not routed");

    property p_smbus_route;
        @(posedge aclk) disable iff (!aresetn)
        captured && !mode_s |=> !serial_clock_pin_oe &&
            serial_data_pin_oe == $past(smbus_sda_drive_low);
    endproperty
    a_smbus_route: assert property (p_smbus_route)
        else $error("smbus mode pins not routed");

    property p_lp_default;
        @(posedge aclk) disable iff (!aresetn)
        captured && !cfg_present && !straps.serial_data_strap &&
            !straps.serial_clock_strap |=>
            low_power.enable && low_power.initiate_enable;
    endproperty
    a_lp_default: assert property (p_lp_default)
        else $error("u1u2 not fully enabled for low straps");

    property p_lp_no_init;
        @(posedge aclk) disable iff (!aresetn)
        captured && !cfg_present && !straps.serial_data_strap &&
            straps.serial_clock_strap |=>
            low_power.enable && !low_power.initiate_enable;
    endproperty
    a_lp_no_init: assert property (p_lp_no_init)
        else $error("u1u2 initiation not inhibited by clock strap");

    property p_lp_data_high;
        @(posedge aclk) disable iff (!aresetn)
        captured && !cfg_present && straps.serial_data_strap |=>
            !low_power.enable && !low_power.initiate_enable;
    endproperty
    a_lp_data_high: assert property (p_lp_data_high)
        else $error("u1u2 not disabled by data strap");

    property p_lp_cfg;
        @(posedge aclk) disable iff (!aresetn)
        captured && cfg_present |=>
            low_power.enable == !$past(cfg_lp_dis) &&
            low_power.initiate_enable == low_power.enable;
    endproperty
    a_lp_cfg: assert property (p_lp_cfg)
        else $error("u1u2 not taken from configuration");

endmodule : ssc_top
`default_nettype wire

// >>> hw/ssc_defines.svh
// constants for the strap capture and serial configuration select block
//
// How it works
// - port-used strap of ports 2 and 3: one means used, zero unused.
// - once straps are taken, those pins drive the green port LEDs.
// - mode select high puts the shared pins on the EEPROM master.
// - mode select low puts the shared pins on the SMBus slave.
// - clock strap low at reset release lets the hub initiate U1/U2.
// - clock strap high: ports never initiate U1/U2, still accept them.
// - clock strap is ignored whenever the data strap was taken high.
// - data strap high at reset release disables U1 and U2.
// - data strap low at reset release keeps U1 and U2 enabled.
// - with a loaded configuration, its disable bit decides U1/U2.
// - with its present bit set, the configuration overrides the clock strap in either mode.
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH

`define SSC_ADDR_W 4
`define SSC_ADDR_STATUS 4'h0
`define SSC_ADDR_DEVCFG 4'h4

`define SSC_DEVCFG_LP_DIS 0
`define SSC_DEVCFG_PRESENT 1
`define SSC_DEVCFG_RESET 2'h0

`define SSC_ST_PORT2 0
`define SSC_ST_PORT3 1
`define SSC_ST_CLK 2
`define SSC_ST_DAT 3
`define SSC_ST_MODE 4
`define SSC_ST_DONE 5
`define SSC_ST_LP_EN 6
`define SSC_ST_INIT_EN 7

`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2

// synchroniser depth plus one edge to settle
`define SSC_SETTLE_W 2
`define SSC_SETTLE_LAST 2'h2

`endif

// >>> hw/ssc_pkg.sv
// types shared by the strap capture and serial configuration select block
package ssc_pkg;

    typedef struct packed {
        logic port3_used;
        logic port2_used;
        logic serial_data_strap;
        logic serial_clock_strap;
    } ssc_straps_t;

    typedef struct packed {
        logic initiate_enable;
        logic enable;
    } ssc_lp_t;

    typedef enum logic [0:0] {
        SSC_SETTLE,
        SSC_RUN
    } ssc_state_t;

endpackage : ssc_pkg

// >>> hw/ssc_sync.sv
// two-flop synchroniser, one lane per bit
`timescale 1ns/1ns
`default_nettype none
module ssc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    for (genvar i = 0; i < WIDTH; i++) begin : g_lane
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                stage1[i] <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                stage1[i] <= async_in[i];
                sync_out[i] <= stage1[i];
            end
        end
    end
endmodule : ssc_sync
`default_nettype wire

// >>> verif/ssc_partner.sv
// pin-side model: strap resistors, open-drain wires, host link clock
`timescale 1ns/1ns
`default_nettype none
module ssc_partner (
    input wire logic [3:0] strap,
    input wire logic frame_on,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic [1:0] led_oe,
    input wire logic [1:0] led_out,
    output logic scl_wire,
    output logic sda_wire,
    output logic [1:0] led_wire
);
    logic lclk;
    // host clock only runs inside a frame, phase unrelated to aclk
    initial begin
        lclk = 1'h0;
        #7;
        forever begin
            #160;
            lclk = frame_on ? ~lclk : 1'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // a device pull wins over the resistor or host level
    assign scl_wire = scl_oe ? 1'h0 : (frame_on ? lclk : strap[0]);
    assign sda_wire = sda_oe ? 1'h0 : strap[1];
    assign led_wire[0] = led_oe[0] ? led_out[0] : strap[2];
    assign led_wire[1] = led_oe[1] ? led_out[1] : strap[3];
endmodule : ssc_partner
`default_nettype wire

// >>> verif/strap_and_serial_config_select_test.sv
// self-checking bench for the strap capture and serial select block
`timescale 1ns/1ns
`include "ssc_defines.svh"
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; \
    if ((got) !== (ex)) begin err_count++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module strap_and_serial_config_select_test
    import ssc_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, arvalid = 1'h0;
    logic bready = 1'h1, rready = 1'h1;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic mode_n = 1'h1, frame_on = 1'h0;
    logic eep_scl = 1'h0, eep_sda = 1'h0, smb_sda = 1'h0;
    logic [3:0] strap = 4'h0;
    logic [1:0] green = 2'h0, led_oe, led_out, led_w, port_used, pin_out;
    logic scl_oe, sda_oe, scl_w, sda_w, scl_lvl, rise, eep_mode;
    logic sda_lvl, fall;
    logic straps_valid;
    ssc_lp_t low_power;
    int err_count = 0, total_checks = 0, cyc = 0;
    int wire_rises = 0, dut_rises = 0, wire_falls = 0, dut_falls = 0;
    logic [33:0] bq[$], rq[$], note;

    ssc_top i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .serial_mode_select_n(mode_n),
        .serial_clock_pin_in(scl_w), .serial_clock_pin_out(pin_out[0]),
        .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda_w),
        .serial_data_pin_out(pin_out[1]), .serial_data_pin_oe(sda_oe),
        .port2_green_led_used_strap_in(led_w[0]),
        .port2_green_led_used_strap_out(led_out[0]),
        .port2_green_led_used_strap_oe(led_oe[0]),
        .port3_green_led_used_strap_in(led_w[1]),
        .port3_green_led_used_strap_out(led_out[1]),
        .port3_green_led_used_strap_oe(led_oe[1]),
        .green_led_on(green), .port_used(port_used),
        .low_power(low_power), .straps_valid(straps_valid),
        .eeprom_scl_drive_low(eep_scl), .eeprom_sda_drive_low(eep_sda),
        .smbus_sda_drive_low(smb_sda), .serial_clock_level(scl_lvl),
        .serial_data_level(sda_lvl), .serial_clock_rise(rise),
        .serial_clock_fall(fall), .eeprom_mode(eep_mode)
    );

    ssc_partner i_partner (
        .strap(strap), .frame_on(frame_on), .scl_oe(scl_oe),
        .sda_oe(sda_oe), .led_oe(led_oe), .led_out(led_out),
        .scl_wire(scl_w), .sda_wire(sda_w), .led_wire(led_w)
    );

    always #20 aclk = ~aclk;
    always @(posedge scl_w) wire_rises++;
    always @(negedge scl_w) wire_falls++;

    ////////////////////////////////////////////////////////////////////
    // response watcher: oldest note against each answer
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (rise) dut_rises <= dut_rises + 1;
        if (fall) dut_falls <= dut_falls + 1;
        if (bvalid && bready) begin
            note = bq.pop_front();
            `CHK("bresp", note[33:32], bresp)
        end
        if (rvalid && rready) begin
            note = rq.pop_front();
            `CHK("rdata", note, {rresp, rdata})
        end
        if (cyc == 8000) begin
            err_count++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////
    // bus tasks start one edge late so no signal is set twice per step
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] er);
        logic aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        bq.push_back({er, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready && !aw_ok) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (wready && !w_ok) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!bvalid);
    endtask : axi_wr

    task automatic axi_rd(input logic [3:0] a, input logic [33:0] ex);
        @(posedge aclk);
        rq.push_back(ex);
        araddr <= a;
        arvalid <= 1'h1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'h0;
        do @(posedge aclk); while (!rvalid);
    endtask : axi_rd

    task automatic do_reset(input int n, input logic [3:0] s);
        aresetn <= 1'h0;
        strap <= s;
        repeat (n) @(posedge aclk);
        `CHK("led_oe_rst", 2'h0, led_oe)
        `CHK("valid_rst", 1'h0, straps_valid)
        aresetn <= 1'h1;
        for (int k = 0; k < 12 && straps_valid !== 1'h1; k++) begin
            @(posedge aclk);
        end
        repeat (2) @(posedge aclk);
        `CHK("straps_valid", 1'h1, straps_valid)
    endtask : do_reset

    // {initiate, enable} from straps when no configuration is loaded
    function automatic logic [1:0] lp_exp(input logic [3:0] s);
        if (s[1]) return 2'h0;
        return {~s[0], 1'h1};
    endfunction : lp_exp

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [3:0] s;
        logic [31:0] st;
        int r0, w0, f0, v0;
        void'($urandom(38));
        do_reset(12, 4'h0);
        for (int i = 0; i < 16; i++) begin
            s = i[3:0];
            mode_n <= 1'($urandom);
            do_reset(3, s);
            `CHK("port_used", s[3:2], port_used)
            `CHK("low_power", lp_exp(s), low_power)
            st = {24'h0, lp_exp(s), 1'h1, mode_n, s[1:0], s[3:2]};
            axi_rd(`SSC_ADDR_STATUS, {`SSC_RESP_OKAY, st});
            green <= 2'($urandom);
            strap <= ~s;
            repeat (4) @(posedge aclk);
            `CHK("led_out", ~green, led_out)
            `CHK("led_oe", 2'h3, led_oe)
            `CHK("held_used", s[3:2], port_used)
            `CHK("held_lp", lp_exp(s), low_power)
        end
        $display("test strap_table done");
        // eeprom mode: clock pull honoured, smbus data pull ignored
        strap <= 4'h3;
        mode_n <= 1'h1;
        eep_scl <= 1'h1;
        smb_sda <= 1'h1;
        repeat (6) @(posedge aclk);
        `CHK("eep_mode", 1'h1, eep_mode)
        `CHK("scl_oe_eep", 1'h1, scl_oe)
        `CHK("sda_oe_eep", 1'h0, sda_oe)
        `CHK("scl_level", 1'h0, scl_lvl)
        `CHK("sda_level", 1'h1, sda_lvl)
        `CHK("pin_out", 2'h0, pin_out)
        eep_sda <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("sda_oe_eep", 1'h1, sda_oe)
        mode_n <= 1'h0;
        smb_sda <= 1'h0;
        eep_sda <= 1'h1;
        repeat (6) @(posedge aclk);
        `CHK("eep_mode", 1'h0, eep_mode)
        `CHK("scl_oe_smb", 1'h0, scl_oe)
        `CHK("sda_oe_smb", 1'h0, sda_oe)
        smb_sda <= 1'h1;
        repeat (2) @(posedge aclk);
        `CHK("sda_oe_smb", 1'h1, sda_oe)
        $display("test pin_routing done");
        // host clocks a frame in; edges must be seen, straps untouched
        eep_scl <= 1'h0;
        eep_sda <= 1'h0;
        smb_sda <= 1'h0;
        strap <= 4'h0;
        repeat (4) @(posedge aclk);
        r0 = dut_rises;
        w0 = wire_rises;
        f0 = dut_falls;
        v0 = wire_falls;
        frame_on <= 1'h1;
        repeat (100) @(posedge aclk);
        frame_on <= 1'h0;
        repeat (10) @(posedge aclk);
        `CHK("clk_rises", wire_rises - w0, dut_rises - r0)
        `CHK("clk_falls", wire_falls - v0, dut_falls - f0)
        `CHK("frame_lp", lp_exp(4'hF), low_power)
        $display("test link_frame done");
        // loaded configuration overrides both straps (both high here)
        axi_wr(`SSC_ADDR_DEVCFG, 32'h2, 4'hF, `SSC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("cfg_lp_on", 2'h3, low_power)
        axi_wr(`SSC_ADDR_DEVCFG, 32'h3, 4'h1, `SSC_RESP_OKAY);
        repeat (3) @(posedge aclk);
        `CHK("cfg_lp_off", 2'h0, low_power)
        axi_wr(`SSC_ADDR_DEVCFG, 32'h0, 4'hE, `SSC_RESP_OKAY);
        axi_wr(`SSC_ADDR_STATUS, 32'hFF, 4'hF, `SSC_RESP_OKAY);
        axi_rd(4'h8, {`SSC_RESP_SLVERR, 32'h0});
        axi_wr(4'hC, 32'h0, 4'hF, `SSC_RESP_SLVERR);
        axi_rd(`SSC_ADDR_DEVCFG, {`SSC_RESP_OKAY, 32'h3});
        do_reset(3, 4'h1);
        `CHK("rst_lp", 2'h1, low_power)
        axi_rd(`SSC_ADDR_DEVCFG, {`SSC_RESP_OKAY, 32'h0});
        repeat (2) @(posedge aclk);
        $display("test config_override done");
        results();
    end
endmodule : strap_and_serial_config_select_test
`default_nettype wire
